// *** inc/rtc_regs.svh ***
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

// Register word indices on the plain register port
`define OFS_CAL_CFG     4'h0
`define OFS_PWR_CTL     4'h1
`define OFS_ALM_CFG     4'h2
`define OFS_ALM_WIN     4'h3
`define OFS_YEAR        4'h4
`define OFS_MONTH_DAY   4'h5
`define OFS_WDAY_HOUR   4'h6
`define OFS_MIN_SEC     4'h7

// Calibration/configuration fields
`define CC_UNIT_ON      15
`define CC_UNLOCK       13
`define CC_HALF         11
`define CC_PIN_ON       10
`define CC_PTR_HI       9
`define CC_PTR_LO       8
`define CC_CAL_HI       7

// Power control fields
`define PC_ON           15
`define PC_POL          14
`define PC_STAB_DIV     13
`define PC_SAMP_DIV     12
`define PC_SRC_HI       11
`define PC_SRC_LO       10
`define PC_OUT_HI       9
`define PC_OUT_LO       8

// Alarm configuration fields
`define AC_ON           15
`define AC_CHIME        14
`define AC_PERIOD_HI    13
`define AC_PERIOD_LO    10
`define AC_INDEX_HI     9
`define AC_INDEX_LO     8

// Reset values
`define RST_CAL_CFG     16'h0000
`define RST_PWR_CTL     16'h0000
`define RST_ALM_CFG     16'h0000
`define RST_YEAR        16'h0000
`define RST_MONTH_DAY   16'h0101
`define RST_WDAY_HOUR   16'h0000
`define RST_MIN_SEC     16'h0000

// Implemented-bit masks; other bits read as zero
`define MASK_CAL_CFG    16'hbfff
`define MASK_PWR_CTL    16'hff00
`define MASK_YEAR       16'h00ff
`define MASK_MONTH_DAY  16'h1f3f
`define MASK_WDAY_HOUR  16'h073f
`define MASK_MIN_SEC    16'h7f7f

// Timebase pulses per half second for the power-line sources
`define HALF_50HZ       17'h0_0019
`define HALF_60HZ       17'h0_001e

// Drift correction interval in seconds
`define CAL_PERIOD_S    15

`endif

// *** inc/rtc_pkg.sv ***
package rtc_pkg;

   typedef enum logic [1:0] {
      PW_IDLE = 2'b00,
      PW_STAB = 2'b01,
      PW_SAMP = 2'b11
   } pw_state_e;

   typedef logic [15:0] word_t;

   typedef struct packed {
      word_t       cal_cfg;
      word_t       pwr_ctl;
      word_t       alm_cfg;
      word_t       year;
      word_t       month_day;
      word_t       wday_hour;
      word_t       min_sec;
      word_t       alm_ms;
      word_t       alm_wh;
      word_t       alm_md;
      logic [7:0]  stab_len;
      logic [7:0]  sample_len;
      logic [2:0]  src_s1;
      logic [2:0]  src_s2;
      logic        src_prev;
      logic [16:0] presc;
      pw_state_e   pw_state;
      logic [7:0]  pw_cnt;
      logic        pw_div;
      logic        alarm_pulse;
      logic        pwr_q;
      logic        pin_q;
      word_t       rdata;
   } st_s;

endpackage

// *** rtl/rtc_calendar_alarm_power_ctrl.sv ***
// Functional notes
// - Positive calibration adds pulses each 15 seconds
// - Negative calibration subtracts pulses each 15 seconds
// - Config and power registers cleared only at power-on
// - Unit enable writable only while unlocked
// - Minute/second write clears half-second flag
// - Power control bit switches power function
// - Polarity bit picks active-high or active-low output
// - Window prescaler bits divide source by two
// - Timebase select picks crystal, internal, 50/60 Hz
// - Output select routes alarm, seconds, source, power
// - Alarm disables itself when repeats exhausted
// - Chime wraps repeat count, else stops
// - Alarm period code picks match fields
// - February 29 yearly alarm fires leap years only
// - Alarm window index maps register pairs
// - Alarm window high access decrements index, saturating
// - Repeat counter decrements on each alarm while nonzero
// - Year holds two BCD digits, upper byte zero
// - Calendar fields BCD, unused bits read zero
// - Minutes and seconds held as BCD digits
// - Calendar writes blocked while locked
// - Unlock bit opens time values for writes
`timescale 1ns/1ps
`include "rtc_regs.svh"

module rtc_calendar_alarm_power_ctrl #(
   parameter logic [16:0] HALF_SECONDARY_CRYSTAL_OSC = 17'h0_4000,
   parameter logic [16:0] HALF_LOW_POWER_INTERNAL_OSC = 17'h0_3d09
) (
   input  wire logic            clk,
   input  wire logic            rst_n,
   input  wire logic            warm_reset,
   input  wire logic [3:0]      addr,
   input  wire rtc_pkg::word_t  wdata,
   input  wire logic            wr,
   input  wire logic            rd,
   output      rtc_pkg::word_t  rdata,
   input  wire logic            secondary_crystal_osc,
   input  wire logic            low_power_internal_osc,
   input  wire logic            line_in,
   output      logic            alarm_pulse,
   output      logic            pwr_ctl_pin,
   output      logic            rtc_pin
);
   import rtc_pkg::*;

   st_s s_r;
   st_s s_nxt;

   // BCD increment that wraps from last back to first
   function automatic logic [7:0] bcd_inc(input logic [7:0] v,
                                          input logic [7:0] last,
                                          input logic [7:0] first);
      if (v == last) begin
         return first;
      end else if (v[3:0] == 4'h9) begin
         return {v[7:4] + 4'h1, 4'h0};
      end else begin
         return {v[7:4], v[3:0] + 4'h1};
      end
   endfunction

   // Years 2000-2099: divisible by four means leap
   function automatic logic [7:0] month_last(input logic [7:0] mon,
                                             input logic [7:0] yr);
      logic [1:0] m4;
      m4 = {yr[4], 1'b0} + yr[1:0];
      unique case (mon)
         8'h02:                       return (m4 == 2'h0) ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
         default:                     return 8'h31;
      endcase
   endfunction

   logic        src_lvl;
   logic        tick;
   logic [16:0] half_cnt;
   logic        half_tick;
   logic        sec_tick;
   logic        cal_due;
   logic        unlocked;
   logic        match;
   logic        alarm_evt;
   logic        c_sec;
   logic        c_min;
   logic        c_hour;
   logic        c_day;
   logic        c_mon;
   logic [7:0]  n_sec;
   logic [7:0]  n_min;
   logic [7:0]  n_hour;
   logic [7:0]  n_day;
   logic [7:0]  n_mon;
   logic [7:0]  n_year;
   logic [2:0]  n_wday;
   logic        stab_tick;
   logic        samp_tick;
   logic        pwr_active;
   logic [1:0]  win_idx;
   logic        ms_hit;
   logic        hit_wr;

   always_comb begin
      s_nxt = s_r;
      unlocked = s_r.cal_cfg[`CC_UNLOCK];

      // Only the second stage of each synchroniser feeds logic
      s_nxt.src_s1 = {line_in, low_power_internal_osc,
                      secondary_crystal_osc};
      s_nxt.src_s2 = s_r.src_s1;

      unique case (s_r.pwr_ctl[`PC_SRC_HI:`PC_SRC_LO])
         2'b00: begin
            src_lvl  = s_r.src_s2[0];
            half_cnt = HALF_SECONDARY_CRYSTAL_OSC;
         end
         2'b01: begin
            src_lvl  = s_r.src_s2[1];
            half_cnt = HALF_LOW_POWER_INTERNAL_OSC;
         end
         2'b10: begin
            src_lvl  = s_r.src_s2[2];
            half_cnt = `HALF_50HZ;
         end
         2'b11: begin
            src_lvl  = s_r.src_s2[2];
            half_cnt = `HALF_60HZ;
         end
      endcase
      s_nxt.src_prev = src_lvl;
      tick = src_lvl & ~s_r.src_prev;

      // Half-second prescaler, signed so calibration can preload it
      half_tick = 1'b0;
      if (s_r.cal_cfg[`CC_UNIT_ON] && tick) begin
         if ($signed(s_r.presc) >= $signed(half_cnt - 17'h0_0001)) begin
            half_tick    = 1'b1;
            s_nxt.presc  = 17'h0_0000;
         end else begin
            s_nxt.presc  = s_r.presc + 17'h0_0001;
         end
      end
      sec_tick = half_tick & s_r.cal_cfg[`CC_HALF];
      if (half_tick) begin
         s_nxt.cal_cfg[`CC_HALF] = ~s_r.cal_cfg[`CC_HALF];
      end

      // Calendar advance on the second boundary
      n_sec  = bcd_inc(s_r.min_sec[7:0], 8'h59, 8'h00);
      c_sec  = (s_r.min_sec[7:0] == 8'h59);
      n_min  = bcd_inc(s_r.min_sec[15:8], 8'h59, 8'h00);
      c_min  = (s_r.min_sec[15:8] == 8'h59);
      n_hour = bcd_inc(s_r.wday_hour[7:0], 8'h23, 8'h00);
      c_hour = (s_r.wday_hour[7:0] == 8'h23);
      n_wday = (s_r.wday_hour[10:8] >= 3'h6) ? 3'h0
                                            : s_r.wday_hour[10:8] + 3'h1;
      n_day  = bcd_inc(s_r.month_day[7:0],
                       month_last(s_r.month_day[15:8], s_r.year[7:0]),
                       8'h01);
      c_day  = (s_r.month_day[7:0] ==
                month_last(s_r.month_day[15:8], s_r.year[7:0]));
      n_mon  = bcd_inc(s_r.month_day[15:8], 8'h12, 8'h01);
      c_mon  = (s_r.month_day[15:8] == 8'h12);
      n_year = bcd_inc(s_r.year[7:0], 8'h99, 8'h00);

      cal_due = 1'b0;
      if (sec_tick) begin
         s_nxt.min_sec[7:0] = n_sec;
         if (c_sec) begin
            s_nxt.min_sec[15:8] = n_min;
            if (c_min) begin
               s_nxt.wday_hour[7:0] = n_hour;
               if (c_hour) begin
                  s_nxt.wday_hour[10:8] = n_wday;
                  s_nxt.month_day[7:0]  = n_day;
                  if (c_day) begin
                     s_nxt.month_day[15:8] = n_mon;
                     if (c_mon) begin
                        s_nxt.year[7:0] = n_year;
                     end
                  end
               end
            end
         end
         cal_due = (n_sec[3:0] == 4'h0 || n_sec[3:0] == 4'h5) &&
                   (n_sec == 8'h00 || n_sec == 8'h15 ||
                    n_sec == 8'h30 || n_sec == 8'h45);
      end
      // Drift correction: a head start adds pulses, a deficit drops them
      if (cal_due) begin
         s_nxt.presc = {{9{s_r.cal_cfg[`CC_CAL_HI]}}, s_r.cal_cfg[7:0]};
      end

      // Alarm comparison against the time being entered
      unique case (s_r.alm_cfg[`AC_PERIOD_HI:`AC_PERIOD_LO])
         4'h0: match = half_tick;
         4'h1: match = sec_tick;
         4'h2: match = sec_tick && s_nxt.min_sec[3:0] == s_r.alm_ms[3:0];
         4'h3: match = sec_tick && s_nxt.min_sec[7:0] == s_r.alm_ms[7:0];
         4'h4: match = sec_tick &&
                       s_nxt.min_sec[11:0] == s_r.alm_ms[11:0];
         4'h5: match = sec_tick && s_nxt.min_sec == s_r.alm_ms;
         4'h6: match = sec_tick && s_nxt.min_sec == s_r.alm_ms &&
                       s_nxt.wday_hour[7:0] == s_r.alm_wh[7:0];
         4'h7: match = sec_tick && s_nxt.min_sec == s_r.alm_ms &&
                       s_nxt.wday_hour == s_r.alm_wh;
         4'h8: match = sec_tick && s_nxt.min_sec == s_r.alm_ms &&
                       s_nxt.wday_hour[7:0] == s_r.alm_wh[7:0] &&
                       s_nxt.month_day[7:0] == s_r.alm_md[7:0];
         // Day 29 of month 2 only exists in leap years
         4'h9: match = sec_tick && s_nxt.min_sec == s_r.alm_ms &&
                       s_nxt.wday_hour[7:0] == s_r.alm_wh[7:0] &&
                       s_nxt.month_day == s_r.alm_md;
         default: match = 1'b0;
      endcase
      alarm_evt = match & s_r.alm_cfg[`AC_ON];
      s_nxt.alarm_pulse = alarm_evt;

      if (alarm_evt) begin
         if (s_r.alm_cfg[7:0] != 8'h00) begin
            s_nxt.alm_cfg[7:0] = s_r.alm_cfg[7:0] - 8'h01;
         end else if (s_r.alm_cfg[`AC_CHIME]) begin
            s_nxt.alm_cfg[7:0] = 8'hff;
         end else begin
            s_nxt.alm_cfg[`AC_ON] = 1'b0;
         end
      end

      // Power-control windows counted in source pulses
      if (tick) begin
         s_nxt.pw_div = ~s_r.pw_div;
      end
      stab_tick = tick & (~s_r.pwr_ctl[`PC_STAB_DIV] | s_r.pw_div);
      samp_tick = tick & (~s_r.pwr_ctl[`PC_SAMP_DIV] | s_r.pw_div);
      unique case (s_r.pw_state)
         PW_IDLE: begin
            if (alarm_evt && s_r.pwr_ctl[`PC_ON]) begin
               if (s_r.stab_len != 8'h00) begin
                  s_nxt.pw_state = PW_STAB;
                  s_nxt.pw_cnt   = s_r.stab_len;
               end else if (s_r.sample_len != 8'h00) begin
                  s_nxt.pw_state = PW_SAMP;
                  s_nxt.pw_cnt   = s_r.sample_len;
               end
            end
         end
         PW_STAB: begin
            if (stab_tick) begin
               s_nxt.pw_cnt = s_r.pw_cnt - 8'h01;
               if (s_r.pw_cnt == 8'h01) begin
                  s_nxt.pw_cnt   = s_r.sample_len;
                  s_nxt.pw_state = (s_r.sample_len != 8'h00) ? PW_SAMP
                                                             : PW_IDLE;
               end
            end
         end
         PW_SAMP: begin
            if (samp_tick && s_r.sample_len != 8'hff) begin
               s_nxt.pw_cnt = s_r.pw_cnt - 8'h01;
               if (s_r.pw_cnt == 8'h01) begin
                  s_nxt.pw_state = PW_IDLE;
               end
            end
         end
         default: s_nxt.pw_state = PW_IDLE;
      endcase
      if (!s_r.pwr_ctl[`PC_ON]) begin
         s_nxt.pw_state = PW_IDLE;
      end
      // An all-ones sample length keeps the window open regardless
      pwr_active = (s_r.pwr_ctl[`PC_ON] && s_r.pw_state != PW_IDLE) ||
                   s_r.sample_len == 8'hff;
      s_nxt.pwr_q = s_r.pwr_ctl[`PC_POL] ? pwr_active : ~pwr_active;

      unique case (s_r.pwr_ctl[`PC_OUT_HI:`PC_OUT_LO])
         2'b00: s_nxt.pin_q = s_r.alarm_pulse;
         2'b01: s_nxt.pin_q = ~s_r.cal_cfg[`CC_HALF];
         2'b10: s_nxt.pin_q = src_lvl;
         2'b11: s_nxt.pin_q = s_r.pwr_q;
      endcase
      if (!s_r.cal_cfg[`CC_PIN_ON]) begin
         s_nxt.pin_q = 1'b0;
      end

      // Register port
      win_idx = s_r.alm_cfg[`AC_INDEX_HI:`AC_INDEX_LO];
      ms_hit  = 1'b0;
      hit_wr  = 1'b0;
      s_nxt.rdata = 16'h0000;
      if (wr) begin
         unique case (addr)
            `OFS_CAL_CFG: begin
               s_nxt.cal_cfg[`CC_UNLOCK] = wdata[`CC_UNLOCK];
               s_nxt.cal_cfg[`CC_PIN_ON] = wdata[`CC_PIN_ON];
               s_nxt.cal_cfg[`CC_PTR_HI:`CC_PTR_LO] =
                  wdata[`CC_PTR_HI:`CC_PTR_LO];
               s_nxt.cal_cfg[7:0] = wdata[7:0];
               if (unlocked) begin
                  s_nxt.cal_cfg[`CC_UNIT_ON] = wdata[`CC_UNIT_ON];
               end
            end
            `OFS_PWR_CTL: s_nxt.pwr_ctl = wdata & `MASK_PWR_CTL;
            `OFS_ALM_CFG: s_nxt.alm_cfg = wdata;
            `OFS_ALM_WIN: begin
               hit_wr = 1'b1;
               unique case (win_idx)
                  2'b00: s_nxt.alm_ms = wdata & `MASK_MIN_SEC;
                  2'b01: s_nxt.alm_wh = wdata & `MASK_WDAY_HOUR;
                  2'b10: s_nxt.alm_md = wdata & `MASK_MONTH_DAY;
                  2'b11: begin
                     if (unlocked) begin
                        s_nxt.stab_len   = wdata[15:8];
                        s_nxt.sample_len = wdata[7:0];
                     end
                  end
               endcase
            end
            `OFS_YEAR: begin
               if (unlocked) begin
                  s_nxt.year = wdata & `MASK_YEAR;
               end
            end
            `OFS_MONTH_DAY: begin
               if (unlocked) begin
                  s_nxt.month_day = wdata & `MASK_MONTH_DAY;
               end
            end
            `OFS_WDAY_HOUR: begin
               if (unlocked) begin
                  s_nxt.wday_hour = wdata & `MASK_WDAY_HOUR;
               end
            end
            `OFS_MIN_SEC: begin
               ms_hit = 1'b1;
               if (unlocked) begin
                  s_nxt.min_sec = wdata & `MASK_MIN_SEC;
               end
            end
            default: ;
         endcase
      end
      if (rd) begin
         unique case (addr)
            `OFS_CAL_CFG:   s_nxt.rdata = s_r.cal_cfg & `MASK_CAL_CFG;
            `OFS_PWR_CTL:   s_nxt.rdata = s_r.pwr_ctl;
            `OFS_ALM_CFG:   s_nxt.rdata = s_r.alm_cfg;
            `OFS_ALM_WIN: begin
               hit_wr = 1'b1;
               unique case (win_idx)
                  2'b00: s_nxt.rdata = s_r.alm_ms;
                  2'b01: s_nxt.rdata = s_r.alm_wh;
                  2'b10: s_nxt.rdata = s_r.alm_md;
                  2'b11: s_nxt.rdata = {s_r.stab_len, s_r.sample_len};
               endcase
            end
            `OFS_YEAR:      s_nxt.rdata = s_r.year;
            `OFS_MONTH_DAY: s_nxt.rdata = s_r.month_day;
            `OFS_WDAY_HOUR: s_nxt.rdata = s_r.wday_hour;
            `OFS_MIN_SEC:   s_nxt.rdata = s_r.min_sec;
            default:        s_nxt.rdata = 16'h0000;
         endcase
      end
      // Saturating index step; a config write in the same cycle wins
      if (hit_wr && win_idx != 2'b00 && !(wr && addr == `OFS_ALM_CFG)) begin
         s_nxt.alm_cfg[`AC_INDEX_HI:`AC_INDEX_LO] = win_idx - 2'b01;
      end
      // Writing seconds restarts the half-second phase and prescaler
      if (ms_hit) begin
         s_nxt.cal_cfg[`CC_HALF] = 1'b0;
         s_nxt.presc = 17'h0_0000;
      end

      // Warm reset spares the config and power registers
      if (warm_reset) begin
         s_nxt.alm_cfg  = `RST_ALM_CFG;
         s_nxt.pw_state = PW_IDLE;
         s_nxt.presc    = 17'h0_0000;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r            <= '0;
         s_r.cal_cfg    <= `RST_CAL_CFG;
         s_r.pwr_ctl    <= `RST_PWR_CTL;
         s_r.alm_cfg    <= `RST_ALM_CFG;
         s_r.year       <= `RST_YEAR;
         s_r.month_day  <= `RST_MONTH_DAY;
         s_r.wday_hour  <= `RST_WDAY_HOUR;
         s_r.min_sec    <= `RST_MIN_SEC;
         s_r.pw_state   <= PW_IDLE;
         s_r.pwr_q      <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rdata       = s_r.rdata;
   assign alarm_pulse = s_r.alarm_pulse;
   assign pwr_ctl_pin = s_r.pwr_q;
   assign rtc_pin     = s_r.pin_q;

endmodule

// *** dv/timebase_model.sv ***
`timescale 1ns/1ps
module timebase_model #(
   parameter int XTAL_HALF_NS = 80,
   parameter int LOW_POWER_INTERNAL_OSC_HALF_NS = 100,
   parameter int LINE_HALF_NS = 60
) (
   output logic secondary_crystal_osc,
   output logic low_power_internal_osc,
   output logic line_in
);
   // Odd start offsets keep source edges clear of the system clock edges
   initial begin
      secondary_crystal_osc = 1'b0;
      #7;
      forever #(XTAL_HALF_NS) secondary_crystal_osc = ~secondary_crystal_osc;
   end
   initial begin
      low_power_internal_osc = 1'b0;
      #3;
      forever #(LOW_POWER_INTERNAL_OSC_HALF_NS) low_power_internal_osc = ~low_power_internal_osc;
   end
   initial begin
      line_in = 1'b0;
      #13;
      forever #(LINE_HALF_NS) line_in = ~line_in;
   end
endmodule

// *** dv/rtc_ctrl_sva.sv ***
`timescale 1ns/1ps
module rtc_ctrl_sva (
   input wire logic           clk,
   input wire logic           rst_n,
   input wire logic           warm_reset,
   input wire logic [3:0]     addr,
   input wire rtc_pkg::word_t wdata,
   input wire logic           wr,
   input wire logic           rd,
   input wire rtc_pkg::word_t rdata,
   input wire logic           secondary_crystal_osc,
   input wire logic           low_power_internal_osc,
   input wire logic           line_in,
   input wire logic           alarm_pulse,
   input wire logic           pwr_ctl_pin,
   input wire logic           rtc_pin
);
   import rtc_pkg::*;
   logic       unlock_r;
   logic       unit_r;
   logic       pin_on_r;
   logic [7:0] pwr_r;
   logic [7:0] year_r;
   // Bus shadows; warm reset must not touch any of them
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         unlock_r <= 1'b0;
         unit_r   <= 1'b0;
         pin_on_r <= 1'b0;
         pwr_r    <= 8'h00;
         year_r   <= 8'h00;
      end else if (wr) begin
         if (addr == 4'h0) begin
            unlock_r <= wdata[13];
            pin_on_r <= wdata[10];
            if (unlock_r) begin
               unit_r <= wdata[15];
            end
         end
         if (addr == 4'h1) begin
            pwr_r <= wdata[15:8];
         end
         if (addr == 4'h4 && unlock_r) begin
            year_r <= wdata[7:0];
         end
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence read_of(logic [3:0] a);
      rd && addr == a;
   endsequence
   sequence min_sec_write;
      wr && addr == 4'h7;
   endsequence
   cfg_lock_a: assert property (
      read_of(4'h0) |=> rdata[15] == unit_r && rdata[13] == unlock_r)
      else $error("unit or unlock bit wrong");
   pwr_keep_a: assert property (
      read_of(4'h1) |=> rdata == {pwr_r, 8'h00})
      else $error("power control read-back wrong");
   year_lock_a: assert property (
      read_of(4'h4) |=> rdata == {8'h00, year_r})
      else $error("year read-back wrong");
   md_bits_a: assert property (
      read_of(4'h5) |=> (rdata & 16'he0c0) == 16'h0000)
      else $error("month/day unused bits set");
   wh_bits_a: assert property (
      read_of(4'h6) |=> (rdata & 16'hf8c0) == 16'h0000)
      else $error("weekday/hour unused bits set");
   ms_bits_a: assert property (
      read_of(4'h7) |=> (rdata & 16'h8080) == 16'h0000)
      else $error("minute/second unused bits set");
   half_clear_a: assert property (
      min_sec_write ##[1:3] read_of(4'h0) |=> !rdata[11])
      else $error("half flag not cleared");
   // Pulses are at least four cycles apart; a source period here is six cycles or more
   alarm_gap_a: assert property (
      alarm_pulse |=> !alarm_pulse [*3])
      else $error("alarm pulse too long");
   pwr_idle_a: assert property (
      !pwr_r[7] && $stable(pwr_r) |-> pwr_ctl_pin == !pwr_r[6])
      else $error("power pin active while off");
   pin_off_a: assert property (
      !pin_on_r && $stable(pin_on_r) |-> !rtc_pin)
      else $error("output pin active while off");
endmodule

// *** dv/rtc_calendar_alarm_power_ctrl_test.sv ***
`timescale 1ns/1ps
module rtc_calendar_alarm_power_ctrl_test;
   import rtc_pkg::*;
   logic       clk;
   logic       rst_n;
   logic       warm_reset;
   logic [3:0] addr;
   word_t      wdata;
   logic       wr;
   logic       rd;
   word_t      rdata;
   logic       secondary_crystal_osc;
   logic       low_power_internal_osc;
   logic       line_in;
   logic       alarm_pulse;
   logic       pwr_ctl_pin;
   logic       rtc_pin;
   int         fails;
   int         samples_checked;
   int         pin_hits;
   int         n;
   int         t;
   int         k;
   word_t      d;
   // Address, write data, expected read-back
   localparam logic [35:0] ROWS [12] = '{
      36'h0_2000_2000, 36'h1_f5ff_f500, 36'h4_ff99_0099,
      36'h5_e229_0229, 36'h6_fe23_0623, 36'h7_d959_5959,
      36'h2_4c00_4c00, 36'h8_1234_0000, 36'h0_0000_0000,
      36'h4_0012_0099, 36'h0_8000_0000, 36'h7_0001_5959
   };
   localparam word_t WIN [4] = '{16'h0302, 16'h1225, 16'h0623, 16'h0000};
   localparam int GAP [4] = '{32, 2 * 32, 20 * 32, 120 * 32};
   localparam int SGAP [4] = '{4 * 8, 4 * 10, 25 * 6, 30 * 6};
   localparam logic [7:0] CAL [3] = '{8'h03, 8'hfe, 8'h80};
   localparam int CSUM [3] = '{960 - 3 * 8, 960 + 2 * 8, 960 + 128 * 8};
   localparam word_t PW [2] = '{16'hc300, 16'hb300};
   localparam int PLO [2] = '{30, 50};
   localparam int PHI [2] = '{44, 90};

   rtc_calendar_alarm_power_ctrl #(
      .HALF_SECONDARY_CRYSTAL_OSC(17'h0_0004),
      .HALF_LOW_POWER_INTERNAL_OSC(17'h0_0004)
   ) rtc_calendar_alarm_power_ctrl_inst (
      .clk(clk), .rst_n(rst_n), .warm_reset(warm_reset), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .secondary_crystal_osc(secondary_crystal_osc),
      .low_power_internal_osc(low_power_internal_osc),
      .line_in(line_in), .alarm_pulse(alarm_pulse),
      .pwr_ctl_pin(pwr_ctl_pin), .rtc_pin(rtc_pin)
   );
   timebase_model timebase_model_inst (
      .secondary_crystal_osc(secondary_crystal_osc),
      .low_power_internal_osc(low_power_internal_osc),
      .line_in(line_in)
   );

   task automatic give_verdict();
      if (fails == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input word_t got, input word_t exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: read %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_num(input int got, input int lo, input int hi);
      samples_checked++;
      if (got < lo || got > hi) begin
         fails++;
         $display("Error at %0t: count %0d not in %0d..%0d", $time, got, lo, hi);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input word_t v);
      @(posedge clk);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output word_t v);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 v = rdata;
   endtask
   // Returns cycles up to and including the next alarm pulse
   task automatic wait_alarm(output int c);
      c = 0;
      do begin
         @(posedge clk);
         #1 c++;
         pin_hits += int'(rtc_pin === 1'b1);
      end while (alarm_pulse !== 1'b1 && c < 9000);
      if (c >= 9000) begin
         fails++;
         give_verdict();
      end
   endtask

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      rst_n = 1'b0;
      warm_reset = 1'b0;
      addr = 4'h0;
      wdata = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
      fails = 0;
      samples_checked = 0;
      pin_hits = 0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      for (k = 0; k < 8; k++) begin
         rd_reg(4'(k), d);
         chk(d, (k == 5) ? 16'h0101 : 16'h0000);
      end
      for (k = 0; k < 12; k++) begin
         wr_reg(ROWS[k][35:32], ROWS[k][31:16]);
         rd_reg(ROWS[k][35:32], d);
         chk(d, ROWS[k][15:0]);
      end
      wr_reg(4'h0, 16'h2000);
      wr_reg(4'h2, 16'h0300);
      for (k = 0; k < 4; k++) begin
         wr_reg(4'h3, WIN[k]);
         rd_reg(4'h2, d);
         chk(d, word_t'((k < 3) ? 2 - k : 0) << 8);
      end
      wr_reg(4'h2, 16'h0300);
      for (k = 0; k < 4; k++) begin
         rd_reg(4'h3, d);
         chk(d, WIN[k]);
      end
      wr_reg(4'h2, 16'h4c05);
      @(posedge clk);
      warm_reset <= 1'b1;
      @(posedge clk);
      warm_reset <= 1'b0;
      rd_reg(4'h2, d);
      chk(d, 16'h0000);
      rd_reg(4'h0, d);
      chk(d, 16'h2000);
      rd_reg(4'h1, d);
      chk(d, 16'hf500);
      // Active-high power pin, crystal source, alarm routed to the pin
      wr_reg(4'h1, 16'h4000);
      wr_reg(4'h0, 16'ha400);
      wr_reg(4'h7, 16'h0000);
      rd_reg(4'h0, d);
      chk(d, 16'ha400);
      for (k = 0; k < 4; k++) begin
         wr_reg(4'h2, 16'hc000 | (word_t'(k) << 10));
         wait_alarm(n);
         pin_hits = 0;
         wait_alarm(n);
         chk_num(n, GAP[k], GAP[k]);
         chk_num(pin_hits, 1, 1);
      end
      wr_reg(4'h2, 16'hc000);
      for (k = 0; k < 4; k++) begin
         wr_reg(4'h1, 16'h4000 | (word_t'(k) << 10));
         wr_reg(4'h7, 16'h0000);
         wait_alarm(n);
         wait_alarm(n);
         chk_num(n, SGAP[k], SGAP[k]);
      end
      wr_reg(4'h1, 16'h4000);
      wr_reg(4'h7, 16'h0000);
      for (k = 0; k < 3; k++) begin
         wr_reg(4'h0, 16'ha400 | {8'h00, CAL[k]});
         wait_alarm(n);
         t = 0;
         repeat (30) begin
            wait_alarm(n);
            t += n;
         end
         chk_num(t, CSUM[k], CSUM[k]);
      end
      wr_reg(4'h0, 16'ha400);
      wr_reg(4'h7, 16'h0000);
      wr_reg(4'h2, 16'h8002);
      n = 0;
      repeat (300) begin
         @(posedge clk);
         #1 n += int'(alarm_pulse === 1'b1);
      end
      chk_num(n, 3, 3);
      rd_reg(4'h2, d);
      chk(d, 16'h0000);
      wr_reg(4'h2, 16'hc000);
      wait_alarm(n);
      rd_reg(4'h2, d);
      chk(d, 16'hc0ff);
      for (k = 0; k < 2; k++) begin
         wr_reg(4'h1, PW[k]);
         wr_reg(4'h7, 16'h0000);
         wr_reg(4'h2, 16'h8400);
         wait_alarm(n);
         n = 0;
         t = 0;
         repeat (150) begin
            @(posedge clk);
            #1 n += int'(pwr_ctl_pin === (k == 0));
            t += int'(rtc_pin === (k == 0));
         end
         chk_num(n, PLO[k], PHI[k]);
         chk_num(t, n, n);
      end
      give_verdict();
   end
endmodule

bind rtc_calendar_alarm_power_ctrl rtc_ctrl_sva rtc_ctrl_sva_inst (
   .clk(clk), .rst_n(rst_n), .warm_reset(warm_reset), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .secondary_crystal_osc(secondary_crystal_osc),
   .low_power_internal_osc(low_power_internal_osc),
   .line_in(line_in), .alarm_pulse(alarm_pulse),
   .pwr_ctl_pin(pwr_ctl_pin), .rtc_pin(rtc_pin)
);
